// File: core/dflash_access.sv
// data flash byte access controller with array storage
`timescale 1ns/1ps
module dflash_access (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire dflash_pkg::sw_req_type req_in,
    input wire logic write_protect_in,
    input wire logic code_protect_in,
    input wire logic port_rd_in,
    input wire logic port_wr_in,
    input wire logic [7:0] port_addr_in,
    input wire logic [7:0] port_data_in,
    output dflash_pkg::sw_stat_type stat_out,
    output logic [7:0] port_data_out,
    output logic port_refused_out
);
    import dflash_pkg::*;

    logic rst_sync1_q, rst_sync2_q;
    logic rst_n;
    logic en_q, en_d;
    logic busy_q, busy_d;
    logic irq_q, irq_d;
    logic err_q, err_d;
    logic [21:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    logic [7:0] wr_data_q, wr_data_d;
    logic [7:0] wr_idx_q, wr_idx_d;
    unlock_state_type key_q, key_d;
    logic [15:0] pwrt_q, pwrt_d;
    logic [7:0] mem_q [ARRAY_DEPTH];
    logic [7:0] pdata_q, pdata_d;
    logic prefuse_q, prefuse_d;
    logic pwrt_run;
    logic start;
    logic t_erase, t_prog, t_done;
    logic addr_ok;

    // reset release through two flops
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_n = rst_sync2_q;

    // power-up interval counter, keyed array writes locked until it expires; port writes are not
    always_comb begin
        pwrt_d = pwrt_q;
        if (pwrt_q != 16'h0000) begin
            pwrt_d = pwrt_q - 16'h0001;
        end
    end
    assign pwrt_run = (pwrt_q != 16'h0000);

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pwrt_q <= 16'(PWRT_CYCLES);
        end else begin
            pwrt_q <= pwrt_d;
        end
    end

    assign addr_ok = in_flash_window(addr_q);

    // write start: enable, unlock armed, strobe, not already busy
    assign start = req_in.wr_set && en_q && (key_q == K_ARMED) && !busy_q
        && addr_ok && !write_protect_in && !pwrt_run;

    // unlock sequencer: any other software write in between cancels it
    always_comb begin
        key_d = key_q;
        if (req_in.key_we) begin
            if (req_in.key == UNLOCK_KEY_FIRST) begin
                key_d = K_FIRST;
            end else if (req_in.key == UNLOCK_KEY_SECOND && key_q == K_FIRST) begin
                key_d = K_ARMED;
            end else begin
                key_d = K_NONE;
            end
        end else if (req_in.addr_we || req_in.data_we || req_in.wr_set || req_in.rd_set
                     || req_in.sector_read_command || req_in.secwr_set || req_in.en_set
                     || req_in.en_clr || req_in.irq_clr || req_in.err_clr) begin
            key_d = K_NONE;
        end
    end

    // control, status and data register next values
    always_comb begin
        en_d = en_q;
        busy_d = busy_q;
        irq_d = irq_q;
        err_d = err_q;
        addr_d = addr_q;
        data_d = data_q;
        wr_data_d = wr_data_q;
        wr_idx_d = wr_idx_q;
        // enable is touched only by software; no hardware clear path
        if (req_in.en_set) begin
            en_d = 1'b1;
        end else if (req_in.en_clr) begin
            en_d = 1'b0;
        end
        // software clears first so a same-cycle hardware set wins
        if (req_in.irq_clr) begin
            irq_d = 1'b0;
        end
        if (req_in.err_clr) begin
            err_d = 1'b0;
        end
        if (!busy_q) begin
            if (req_in.addr_we) begin
                addr_d = req_in.addr;
            end
            if (req_in.data_we) begin
                data_d = req_in.data;
            end
            if (req_in.rd_set && en_q && addr_ok) begin
                data_d = mem_q[addr_q[7:0]];
            end
        end
        if (start) begin
            busy_d = 1'b1;
            wr_data_d = data_q;
            wr_idx_d = addr_q[7:0];
        end else if (req_in.wr_set && en_q && !busy_q && key_q == K_ARMED) begin
            err_d = 1'b1;
        end
        // sector operations on the data flash are refused with an error
        if ((req_in.sector_read_command || req_in.secwr_set) && en_q && !busy_q
            && key_q == K_ARMED && addr_ok) begin
            err_d = 1'b1;
        end
        if (t_done) begin
            busy_d = 1'b0;
            irq_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= 1'b0;
            busy_q <= 1'b0;
            irq_q <= 1'b0;
            err_q <= 1'b0;
            addr_q <= ADDR_RESET;
            data_q <= DATA_RESET;
            wr_data_q <= DATA_RESET;
            wr_idx_q <= 8'h00;
            key_q <= K_NONE;
        end else begin
            en_q <= en_d;
            busy_q <= busy_d;
            irq_q <= irq_d;
            err_q <= err_d;
            addr_q <= addr_d;
            data_q <= data_d;
            wr_data_q <= wr_data_d;
            wr_idx_q <= wr_idx_d;
            key_q <= key_d;
        end
    end

    dflash_prog_timer u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .start_in(start),
        .erase_out(t_erase),
        .program_out(t_prog),
        .done_out(t_done)
    );

    // array cells; erase drives the byte to the erased pattern first
    always_ff @(posedge clk_in) begin
        if (t_erase) begin
            mem_q[wr_idx_q] <= ERASED_BYTE;
        end else if (t_prog) begin
            mem_q[wr_idx_q] <= wr_data_q;
        end else if (port_wr_in && !code_protect_in && !busy_q) begin
            mem_q[port_addr_in] <= port_data_in;
        end
    end

    // programming-port read path, refused under code protection
    always_comb begin
        pdata_d = pdata_q;
        prefuse_d = 1'b0;
        if (port_rd_in || port_wr_in) begin
            if (code_protect_in) begin
                prefuse_d = 1'b1;
            end else if (port_rd_in) begin
                pdata_d = mem_q[port_addr_in];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pdata_q <= DATA_RESET;
            prefuse_q <= 1'b0;
        end else begin
            pdata_q <= pdata_d;
            prefuse_q <= prefuse_d;
        end
    end

    // status view, all from flops
    // one driver for the whole struct keeps lint from seeing split drivers
    assign stat_out = {en_q, busy_q, irq_q, err_q, addr_q, data_q};
    assign port_data_out = pdata_q;
    assign port_refused_out = prefuse_q;

endmodule : dflash_access

// File: core/dflash_pkg.sv
// constants, field layouts and carrier types for the data flash byte access block
package dflash_pkg;

    localparam int ADDR_W = 22;
    localparam int DATA_W = 8;
    localparam int ARRAY_DEPTH = 256;
    localparam int INDEX_W = 8;
    // data flash window in the address space
    localparam logic [21:0] FLASH_WIN_BASE = 22'h310000;
    localparam logic [21:0] FLASH_WIN_LAST = 22'h3100FF;
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [21:0] ADDR_RESET = 22'h000000;
    // programming timer periods
    localparam int ERASE_TIME_NS = 2000;
    localparam int PROGRAM_TIME_NS = 2000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 12;
    localparam int PWRT_TIME_NS = 64000;
    localparam int PWRT_CYCLES = PWRT_TIME_NS / CLK_PERIOD_NS;
    localparam int PWRT_W = 16;

    // software write request carrier
    typedef struct packed {
        logic addr_we;
        logic [21:0] addr;
        logic data_we;
        logic [7:0] data;
        logic key_we;
        logic [7:0] key;
        logic en_set;
        logic en_clr;
        logic rd_set;
        logic wr_set;
        logic sector_read_command;
        logic secwr_set;
        logic irq_clr;
        logic err_clr;
    } sw_req_type;

    // visible status carrier
    typedef struct packed {
        logic access_enable;
        logic write_busy;
        logic completion_irq_flag;
        logic access_error_flag;
        logic [21:0] addr;
        logic [7:0] data;
    } sw_stat_type;

    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_ERASE = 2'b01,
        T_PROGRAM = 2'b10,
        T_DONE = 2'b11
    } prog_state_type;

    typedef enum logic [1:0] {
        K_NONE = 2'b00,
        K_FIRST = 2'b01,
        K_ARMED = 2'b10
    } unlock_state_type;

    // address falls inside the data flash window
    function automatic logic in_flash_window(input logic [21:0] a);
        in_flash_window = (a >= FLASH_WIN_BASE) && (a <= FLASH_WIN_LAST);
    endfunction : in_flash_window

endpackage : dflash_pkg

// File: core/dflash_prog_timer.sv
// internal programming timer: erase phase then program phase
`timescale 1ns/1ps
module dflash_prog_timer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    output logic erase_out,
    output logic program_out,
    output logic done_out
);
    import dflash_pkg::*;

    prog_state_type state_q, state_d;
    logic [11:0] count_q, count_d;

    // next-state: erase then program, each timed by its own count
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        case (state_q)
            T_IDLE: begin
                if (start_in) begin
                    state_d = T_ERASE;
                    count_d = 12'(ERASE_CYCLES - 1);
                end
            end
            T_ERASE: begin
                if (count_q == 12'h000) begin
                    state_d = T_PROGRAM;
                    count_d = 12'(PROGRAM_CYCLES - 1);
                end else begin
                    count_d = count_q - 12'h001;
                end
            end
            T_PROGRAM: begin
                if (count_q == 12'h000) begin
                    state_d = T_DONE;
                end else begin
                    count_d = count_q - 12'h001;
                end
            end
            default: begin
                state_d = T_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= T_IDLE;
            count_q <= 12'h000;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
        end
    end

    assign erase_out = (state_q == T_ERASE);
    assign program_out = (state_q == T_PROGRAM) && (count_q == 12'h000);
    assign done_out = (state_q == T_DONE);

endmodule : dflash_prog_timer

// File: verif/dflash_access_assertions.sv
// port-level checks for the data flash byte access block
`timescale 1ns/1ps
module dflash_access_assertions (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire dflash_pkg::sw_req_type req_in,
    input wire logic write_protect_in,
    input wire logic code_protect_in,
    input wire logic port_rd_in,
    input wire logic port_wr_in,
    input wire logic [7:0] port_addr_in,
    input wire logic [7:0] port_data_in,
    input wire dflash_pkg::sw_stat_type stat_out,
    input wire logic [7:0] port_data_out,
    input wire logic port_refused_out
);
    import dflash_pkg::*;
    // one domain, so clock and reset are given once
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    AST_EN_HOLD: assert property ($fell(stat_out.access_enable)
        |-> $past(req_in.en_clr)) else $error("enable dropped by itself");
    AST_WR_GATED: assert property (req_in.wr_set && !stat_out.access_enable
        && !stat_out.write_busy |=> !stat_out.write_busy)
        else $error("strobe taken without enable");
    AST_IRQ_HOLD: assert property ($fell(stat_out.completion_irq_flag)
        |-> $past(req_in.irq_clr)) else $error("done flag dropped by itself");
    AST_ERR_HOLD: assert property ($fell(stat_out.access_error_flag)
        |-> $past(req_in.err_clr)) else $error("error flag dropped by itself");
    AST_DONE: assert property ($fell(stat_out.write_busy) && !stat_out.access_error_flag
        |-> stat_out.completion_irq_flag) else $error("write ended without done flag");
    AST_WR_BOUND: assert property ($rose(stat_out.write_busy)
        |-> ##[1:600] !stat_out.write_busy) else $error("write never ended");
    AST_LOCK_ADDR: assert property (stat_out.write_busy && req_in.addr_we
        |=> $stable(stat_out.addr)) else $error("address changed during write");
    AST_LOCK_DATA: assert property (stat_out.write_busy && req_in.data_we
        |=> $stable(stat_out.data)) else $error("data changed during write");
    AST_DATA_KEEP: assert property (!req_in.rd_set && !req_in.data_we
        |=> $stable(stat_out.data)) else $error("data register changed by itself");
    AST_PORT_REFUSE: assert property ((port_rd_in || port_wr_in)
        |=> port_refused_out == $past(code_protect_in)) else $error("port refusal wrong");
    AST_SEC_NOWR: assert property (req_in.secwr_set && !req_in.wr_set
        && !stat_out.write_busy |=> !stat_out.write_busy) else $error("sector write started");
endmodule : dflash_access_assertions

// File: verif/dflash_access_tb.sv
// self-checking bench for the data flash byte access block
`timescale 1ns/1ps
module dflash_access_tb;
    import dflash_pkg::*;
    localparam int O_AD = 0, O_DA = 1, O_KY = 2, O_EN = 3, O_EC = 4, O_RD = 5;
    localparam int O_WR = 6, O_SR = 7, O_SW = 8, O_IC = 9, O_XC = 10;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    sw_req_type req_in = '0;
    logic write_protect_in = 1'b0;
    logic code_protect_in = 1'b0;
    logic port_rd_in = 1'b0;
    logic port_wr_in = 1'b0;
    logic [7:0] port_addr_in = 8'h00;
    logic [7:0] port_data_in = 8'h77;
    sw_stat_type stat_out;
    logic [7:0] port_data_out;
    logic port_refused_out;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h00000032;
    logic [7:0] mem_m [int];
    logic [21:0] a;
    logic [7:0] d;
    sw_req_type r;

    // 100 MHz clock
    always #5 clk_in = ~clk_in;

    dflash_access dut_u (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req_in),
        .write_protect_in(write_protect_in), .code_protect_in(code_protect_in),
        .port_rd_in(port_rd_in), .port_wr_in(port_wr_in), .port_addr_in(port_addr_in),
        .port_data_in(port_data_in), .stat_out(stat_out), .port_data_out(port_data_out),
        .port_refused_out(port_refused_out)
    );

    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : nxt

    task automatic wrap_up();
        if (n_fail == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    // inputs always move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    // one request pulse, then an idle cycle so no signal is set twice at once
    task automatic op(input int k, input logic [21:0] v = 22'h000000);
        r = '0;
        r.addr = v;
        r.data = v[7:0];
        r.key = v[7:0];
        r.addr_we = (k == O_AD);
        r.data_we = (k == O_DA);
        r.key_we = (k == O_KY);
        r.en_set = (k == O_EN);
        r.en_clr = (k == O_EC);
        r.rd_set = (k == O_RD);
        r.wr_set = (k == O_WR);
        r.sector_read_command = (k == O_SR);
        r.secwr_set = (k == O_SW);
        r.irq_clr = (k == O_IC);
        r.err_clr = (k == O_XC);
        req_in = r;
        tick(1);
        req_in = '0;
        tick(1);
    endtask : op

    task automatic keyed(input logic [21:0] av, input logic [7:0] dv);
        op(O_AD, av);
        op(O_DA, {14'h0, dv});
        op(O_KY, {14'h0, UNLOCK_KEY_FIRST});
        op(O_KY, {14'h0, UNLOCK_KEY_SECOND});
        op(O_WR);
    endtask : keyed

    // a keyed strobe that must end in the error flag, nothing written
    task automatic refused(input logic [21:0] av);
        keyed(av, 8'h5A);
        tick(2);
        chk(stat_out.write_busy, 1'b0);
        chk(stat_out.access_error_flag, 1'b1);
        op(O_XC);
        chk(stat_out.access_error_flag, 1'b0);
    endtask : refused

    // full write; probe pokes the locked registers while busy
    task automatic wr_ok(input logic [21:0] av, input logic [7:0] dv, input bit probe);
        int n;
        n = 0;
        keyed(av, dv);
        chk(stat_out.write_busy, 1'b1);
        if (probe) begin
            op(O_AD, av ^ 22'h000001);
            op(O_DA, {14'h0, ~dv});
            op(O_EC);
            chk({stat_out.addr, stat_out.data}, {av, dv});
        end
        while (stat_out.write_busy !== 1'b0 && n < 600) begin
            tick(1);
            n++;
        end
        if (n >= 600) begin
            $display("Error at %0t: write never finished", $time);
            n_fail++;
            wrap_up();
        end
        chk(stat_out.completion_irq_flag, 1'b1);
        if (!probe) chk(stat_out.access_enable, 1'b1);
        mem_m[av[7:0]] = dv;
        tick(4);
        chk(stat_out.completion_irq_flag, 1'b1);
        op(O_IC);
        chk(stat_out.completion_irq_flag, 1'b0);
        op(O_EN);
    endtask : wr_ok

    task automatic rd_chk(input logic [21:0] av);
        op(O_AD, av);
        op(O_RD);
        chk(stat_out.data, mem_m[av[7:0]]);
    endtask : rd_chk

    // main sequence
    initial begin
        repeat (10) @(posedge clk_in);
        #1;
        arst_n_in = 1'b1;
        tick(3);
        chk(stat_out, '0);
        op(O_EN);
        refused(FLASH_WIN_BASE);
        tick(PWRT_CYCLES);
        op(O_EC);
        keyed(FLASH_WIN_BASE, 8'h11);
        chk(stat_out.write_busy, 1'b0);
        op(O_EN);
        op(O_WR);
        chk(stat_out.write_busy, 1'b0);
        op(O_KY, 22'h000055);
        op(O_DA, 22'h000012);
        op(O_KY, 22'h0000AA);
        op(O_WR);
        chk(stat_out.write_busy, 1'b0);
        for (int i = 0; i < 6; i++) begin
            d = 8'(nxt());
            a = FLASH_WIN_BASE | {14'h0, d};
            d = (i == 0) ? ERASED_BYTE : 8'(nxt());
            wr_ok(a, d, i == 2);
            rd_chk(a);
        end
        op(O_AD, FLASH_WIN_BASE);
        chk(stat_out.data, d);
        write_protect_in = 1'b1;
        refused(a);
        rd_chk(a);
        write_protect_in = 1'b0;
        code_protect_in = 1'b1;
        wr_ok(a, 8'hA5, 1'b0);
        rd_chk(a);
        port_addr_in = a[7:0];
        port_wr_in = 1'b1;
        tick(1);
        chk(port_refused_out, 1'b1);
        port_wr_in = 1'b0;
        code_protect_in = 1'b0;
        port_rd_in = 1'b1;
        tick(1);
        chk({port_refused_out, port_data_out}, {1'b0, mem_m[a[7:0]]});
        port_rd_in = 1'b0;
        // unprotected port write must land and be seen by the processor read
        port_data_in = 8'(nxt());
        port_wr_in = 1'b1;
        tick(1);
        port_wr_in = 1'b0;
        mem_m[a[7:0]] = port_data_in;
        rd_chk(a);
        refused(FLASH_WIN_LAST + 22'h000001);
        for (int k = O_SR; k <= O_SW; k++) begin
            op(O_AD, FLASH_WIN_BASE);
            op(O_KY, 22'h000055);
            op(O_KY, 22'h0000AA);
            op(k);
            tick(2);
            chk(stat_out.write_busy, 1'b0);
            chk(stat_out.access_error_flag, 1'b1);
            op(O_XC);
        end
        arst_n_in = 1'b0;
        tick(2);
        chk(stat_out.access_enable, 1'b0);
        arst_n_in = 1'b1;
        tick(3);
        wrap_up();
    end
endmodule : dflash_access_tb

bind dflash_access dflash_access_assertions chk_u (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req_in),
    .write_protect_in(write_protect_in), .code_protect_in(code_protect_in),
    .port_rd_in(port_rd_in), .port_wr_in(port_wr_in), .port_addr_in(port_addr_in),
    .port_data_in(port_data_in), .stat_out(stat_out), .port_data_out(port_data_out),
    .port_refused_out(port_refused_out)
);
